// ==== rtl/pcrs_pkg.sv ====
/*
 pcrs_pkg: constants, register indices and the operation codes of the program counter
 and return stack unit.
 Assumes a 10 MHz core clock and 32-bit AXI4-Lite with register index = byte address / 4.
*/
package pcrs_pkg;
	localparam int PC_W = 15;
	localparam int PCH_W = 7;
	localparam int SP_W = 5;
	localparam int DEPTH = 16;
	localparam int IDX_W = 12;

	// register indices, byte address is four times the index
	localparam logic [11:0] IDX_STATUS_SHD = 12'hfe4;
	localparam logic [11:0] IDX_WORK_SHD = 12'hfe5;
	localparam logic [11:0] IDX_BANK_SHD = 12'hfe6;
	localparam logic [11:0] IDX_PCH_SHD = 12'hfe7;
	localparam logic [11:0] IDX_P0L_SHD = 12'hfe8;
	localparam logic [11:0] IDX_P0H_SHD = 12'hfe9;
	localparam logic [11:0] IDX_P1L_SHD = 12'hfea;
	localparam logic [11:0] IDX_P1H_SHD = 12'hfeb;
	localparam logic [11:0] IDX_STACK_PTR = 12'hfed;
	localparam logic [11:0] IDX_TOS_LOW = 12'hfee;
	localparam logic [11:0] IDX_TOS_HIGH = 12'hfef;
	localparam logic [11:0] IDX_PC_LOW = 12'hf00;
	localparam logic [11:0] IDX_PC_LATCH = 12'hf01;
	localparam logic [11:0] IDX_PWR_CTRL = 12'hf02;
	localparam logic [11:0] IDX_CONFIG = 12'hf03;

	localparam int PWR_OVF_BIT = 7;
	localparam int PWR_UNF_BIT = 6;
	localparam int CFG_FAULT_EN_BIT = 0;

	localparam logic [4:0] SP_EMPTY = 5'h1f;
	localparam logic [4:0] SP_ONE = 5'h01;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [14:0] PC_ONE = 15'h0001;
	localparam logic [6:0] PCH_RST = 7'h00;
	localparam logic [14:0] INT_VECTOR = 15'h0004;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		OP_HOLD = 4'h0,
		OP_STEP = 4'h1,
		OP_WR_PCL = 4'h2,
		OP_CALL = 4'h3,
		OP_CALL_VIA_ACCUMULATOR = 4'h4,
		OP_BRW = 4'h5,
		OP_BRA = 4'h6,
		OP_RETURN = 4'h7,
		OP_RETURN_WITH_LITERAL = 4'h8,
		OP_RETURN_FROM_INTERRUPT = 4'h9,
		OP_INT = 4'ha
	} pcrs_op_t;
endpackage

// ==== rtl/pcrs_stack.sv ====
/*
 pcrs_stack: the sixteen-entry return address store, one write port with separate
 low and high halves and one asynchronous read port.
 Assumes the caller resolves write priority; entries hold no reset value.
*/
module pcrs_stack #(
	parameter int DEPTH = pcrs_pkg::DEPTH,
	parameter int W = pcrs_pkg::PC_W
) (
	input wire logic clk,
	input wire logic we_lo,
	input wire logic we_hi,
	input wire logic [3:0] widx,
	input wire logic [W-1:0] wdata,
	input wire logic [3:0] ridx,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we_lo) begin
			mem[widx][7:0] <= wdata[7:0];
		end
		if (we_hi) begin
			mem[widx][W-1:8] <= wdata[W-1:8];
		end
	end

	assign rdata = mem[ridx];
endmodule // pcrs_stack

// ==== rtl/pcrs_core.sv ====
/*
 pcrs_core: program counter sequencing, hardware return stack, stack pointer,
 fault flags and context shadows, with an AXI4-Lite register slave.
 Assumes the instruction decoder presents one operation per clock on core_op while
 core_op_valid is high, and that rstn is the power-on reset.
*/
// The AXI4-Lite slave port was chosen for this implementation.
// Notes on behaviour
// - fifteen-bit counter, low byte register, high from latch
// - every reset clears the whole counter
// - low byte write also loads latch bits
// - call takes operand and latch bits six-three
// - accumulator call takes accumulator and latch
// - accumulator branch adds unsigned accumulator plus one
// - operand branch adds sign-extended operand bits eight-zero plus one
// - sixteen fifteen-bit entries outside address spaces
// - calls and interrupts push, returns pop
// - latch untouched by push or pop, except the interrupt return pop, which restores it from the shadow
// - fault reset off means circular stack
// - overflow and underflow flags always set
// - pointer selects entry seen through top registers
// - pointer is five bits wide
// - push increments then writes, pop reads then decrements
// - empty pointer is all ones, first push zero
// - context shadows kept through non-power resets
// - fault reset on overflow or underflow when enabled
module pcrs_core #(
	parameter int ADDR_W = 14,
	parameter logic [14:0] VECTOR = pcrs_pkg::INT_VECTOR
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_op_valid,
	input wire pcrs_pkg::pcrs_op_t core_op,
	input wire logic [7:0] core_acc,
	input wire logic [10:0] core_operand,
	input wire logic [7:0] core_pcl_data,
	input wire logic [2:0] ctx_status,
	input wire logic [4:0] ctx_bank,
	input wire logic [15:0] ctx_ptr0,
	input wire logic [15:0] ctx_ptr1,
	output logic [14:0] pc_out,
	output logic [6:0] pc_high_latch_out,
	output logic ctx_restore,
	output logic [2:0] shd_status,
	output logic [7:0] shd_acc,
	output logic [4:0] shd_bank,
	output logic [15:0] shd_ptr0,
	output logic [15:0] shd_ptr1,
	output logic stack_fault_reset,
	output logic stack_overflow_flag,
	output logic stack_underflow_flag
);
	localparam int IW = pcrs_pkg::IDX_W;

	logic [14:0] pc_r;
	logic [6:0] pc_high_latch_r;
	logic [4:0] stack_pointer_r;
	logic ovf_r;
	logic unf_r;
	logic fault_en_r;
	logic fault_r;
	logic restore_r;
	logic [2:0] shd_status_r;
	logic [7:0] shd_acc_r;
	logic [4:0] shd_bank_r;
	logic [6:0] shd_pch_r;
	logic [15:0] shd_ptr0_r;
	logic [15:0] shd_ptr1_r;

	logic aw_hold_r;
	logic w_hold_r;
	logic [IW-1:0] wr_idx_r;
	logic [7:0] wr_data_r;
	logic wr_lane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	logic [14:0] tos_rdata;
	logic [14:0] stk_wdata;
	logic [3:0] stk_widx;
	logic stk_we_lo;
	logic stk_we_hi;

	function automatic logic is_mapped(input logic [IW-1:0] idx);
		is_mapped = (idx >= pcrs_pkg::IDX_STATUS_SHD && idx <= pcrs_pkg::IDX_P1H_SHD) ||
			(idx >= pcrs_pkg::IDX_STACK_PTR && idx <= pcrs_pkg::IDX_TOS_HIGH) ||
			(idx >= pcrs_pkg::IDX_PC_LOW && idx <= pcrs_pkg::IDX_CONFIG);
	endfunction

	function automatic logic [14:0] pc_inc(input logic [14:0] pc);
		pc_inc = pc + pcrs_pkg::PC_ONE;
	endfunction

	// core operation decode
	logic op_call, op_call_via_accumulator, op_int, op_return_from_interrupt, push, pop;
	assign op_call = core_op_valid && core_op == pcrs_pkg::OP_CALL;
	assign op_call_via_accumulator = core_op_valid && core_op == pcrs_pkg::OP_CALL_VIA_ACCUMULATOR;
	assign op_int = core_op_valid && core_op == pcrs_pkg::OP_INT;
	assign op_return_from_interrupt = core_op_valid && core_op == pcrs_pkg::OP_RETURN_FROM_INTERRUPT;
	assign push = op_call || op_call_via_accumulator || op_int;
	assign pop = core_op_valid && (core_op == pcrs_pkg::OP_RETURN ||
		core_op == pcrs_pkg::OP_RETURN_WITH_LITERAL || op_return_from_interrupt);

	logic [4:0] sp_up;
	logic ovf_evt, unf_evt, fault_evt;
	assign sp_up = stack_pointer_r + pcrs_pkg::SP_ONE;
	assign ovf_evt = push && sp_up[4];
	assign unf_evt = pop && stack_pointer_r == pcrs_pkg::SP_EMPTY;
	assign fault_evt = fault_en_r && (ovf_evt || unf_evt);

	// bus write decode
	logic wr_fire;
	logic [7:0] wd;
	assign wr_fire = aw_hold_r && w_hold_r && wr_lane_r && !bvalid_r;
	assign wd = wr_data_r;

	function automatic logic bus_wr(input logic fire, input logic [IW-1:0] idx,
		input logic [11:0] target);
		bus_wr = fire && idx == target;
	endfunction

	logic wr_pcl, wr_pch, wr_sp, wr_top_of_stack_low, wr_top_of_stack_high, wr_pwr, wr_cfg;
	assign wr_pcl = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_PC_LOW);
	assign wr_pch = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_PC_LATCH);
	assign wr_sp = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_STACK_PTR);
	assign wr_top_of_stack_low = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_TOS_LOW);
	assign wr_top_of_stack_high = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_TOS_HIGH);
	assign wr_pwr = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_PWR_CTRL);
	assign wr_cfg = bus_wr(wr_fire, wr_idx_r, pcrs_pkg::IDX_CONFIG);

	// return stack; a push beats a software access to the top entry
	always_comb begin
		if (push) begin
			stk_widx = sp_up[3:0];
			stk_wdata = op_int ? pc_r : pc_inc(pc_r);
			stk_we_lo = 1'b1;
			stk_we_hi = 1'b1;
		end else begin
			stk_widx = stack_pointer_r[3:0];
			stk_wdata = {wd[6:0], wd};
			stk_we_lo = wr_top_of_stack_low && !pop;
			stk_we_hi = wr_top_of_stack_high && !pop;
		end
	end

	pcrs_stack #(
		.DEPTH(pcrs_pkg::DEPTH),
		.W(pcrs_pkg::PC_W)
	) u_stack (
		.clk(clk),
		.we_lo(stk_we_lo),
		.we_hi(stk_we_hi),
		.widx(stk_widx),
		.wdata(stk_wdata),
		.ridx(stack_pointer_r[3:0]),
		.rdata(tos_rdata)
	);

	// program counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_r <= pcrs_pkg::PC_RST;
		end else if (fault_evt) begin
			pc_r <= pcrs_pkg::PC_RST;
		end else if (core_op_valid) begin
			unique case (core_op)
				pcrs_pkg::OP_HOLD: pc_r <= pc_r;
				pcrs_pkg::OP_STEP: pc_r <= pc_inc(pc_r);
				pcrs_pkg::OP_WR_PCL: pc_r <= {pc_high_latch_r, core_pcl_data};
				pcrs_pkg::OP_CALL: pc_r <= {pc_high_latch_r[6:3], core_operand};
				pcrs_pkg::OP_CALL_VIA_ACCUMULATOR: pc_r <= {pc_high_latch_r, core_acc};
				pcrs_pkg::OP_BRW: pc_r <= pc_inc(pc_r) + {7'h00, core_acc};
				pcrs_pkg::OP_BRA: pc_r <= pc_inc(pc_r) +
					{{6{core_operand[8]}}, core_operand[8:0]};
				pcrs_pkg::OP_RETURN,
				pcrs_pkg::OP_RETURN_WITH_LITERAL,
				pcrs_pkg::OP_RETURN_FROM_INTERRUPT: pc_r <= tos_rdata;
				pcrs_pkg::OP_INT: pc_r <= VECTOR;
				default: pc_r <= pc_r;
			endcase
		end else if (wr_pcl) begin
			pc_r <= {pc_high_latch_r, wd};
		end
	end

	// high latch; only software and the interrupt return restore touch it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_high_latch_r <= pcrs_pkg::PCH_RST;
		end else if (op_return_from_interrupt) begin
			pc_high_latch_r <= shd_pch_r;
		end else if (wr_pch) begin
			pc_high_latch_r <= wd[6:0];
		end
	end

	// stack pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stack_pointer_r <= pcrs_pkg::SP_EMPTY;
		end else if (fault_evt) begin
			stack_pointer_r <= pcrs_pkg::SP_EMPTY;
		end else if (push) begin
			stack_pointer_r <= sp_up;
		end else if (pop) begin
			stack_pointer_r <= stack_pointer_r - pcrs_pkg::SP_ONE;
		end else if (wr_sp) begin
			stack_pointer_r <= wd[4:0];
		end
	end

	// fault flags: hardware set wins over a software write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ovf_r <= 1'b0;
			unf_r <= 1'b0;
		end else begin
			ovf_r <= ovf_evt || (wr_pwr ? wd[pcrs_pkg::PWR_OVF_BIT] : ovf_r);
			unf_r <= unf_evt || (wr_pwr ? wd[pcrs_pkg::PWR_UNF_BIT] : unf_r);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault_en_r <= 1'b0;
		end else if (wr_cfg) begin
			fault_en_r <= wd[pcrs_pkg::CFG_FAULT_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fault_r <= 1'b0;
			restore_r <= 1'b0;
		end else begin
			fault_r <= fault_evt;
			restore_r <= op_return_from_interrupt && !fault_evt;
		end
	end

	// context shadows: no reset, so they survive every reset but power-on
	always_ff @(posedge clk) begin
		if (op_int) begin
			shd_status_r <= ctx_status;
			shd_acc_r <= core_acc;
			shd_bank_r <= ctx_bank;
			shd_pch_r <= pc_high_latch_r;
			shd_ptr0_r <= ctx_ptr0;
			shd_ptr1_r <= ctx_ptr1;
		end else if (wr_fire) begin
			unique case (wr_idx_r)
				pcrs_pkg::IDX_STATUS_SHD: shd_status_r <= wd[2:0];
				pcrs_pkg::IDX_WORK_SHD: shd_acc_r <= wd;
				pcrs_pkg::IDX_BANK_SHD: shd_bank_r <= wd[4:0];
				pcrs_pkg::IDX_PCH_SHD: shd_pch_r <= wd[6:0];
				pcrs_pkg::IDX_P0L_SHD: shd_ptr0_r[7:0] <= wd;
				pcrs_pkg::IDX_P0H_SHD: shd_ptr0_r[15:8] <= wd;
				pcrs_pkg::IDX_P1L_SHD: shd_ptr1_r[7:0] <= wd;
				pcrs_pkg::IDX_P1H_SHD: shd_ptr1_r[15:8] <= wd;
				default: ;
			endcase
		end
	end

	// AXI4-Lite write channel: address and data captured in either order
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			wr_idx_r <= '0;
			wr_data_r <= 8'h00;
			wr_lane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= pcrs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				wr_idx_r <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wr_data_r <= s_axi_wdata[7:0];
				wr_lane_r <= s_axi_wstrb[0];
			end
			if (aw_hold_r && w_hold_r && !bvalid_r) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(wr_idx_r) ? pcrs_pkg::RESP_OKAY : pcrs_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	logic [IW-1:0] rd_idx;
	logic [7:0] rd_val;
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];
	assign s_axi_arready = !rvalid_r;

	always_comb begin
		rd_val = 8'h00;
		unique case (rd_idx)
			pcrs_pkg::IDX_STATUS_SHD: rd_val = {5'h00, shd_status_r};
			pcrs_pkg::IDX_WORK_SHD: rd_val = shd_acc_r;
			pcrs_pkg::IDX_BANK_SHD: rd_val = {3'h0, shd_bank_r};
			pcrs_pkg::IDX_PCH_SHD: rd_val = {1'b0, shd_pch_r};
			pcrs_pkg::IDX_P0L_SHD: rd_val = shd_ptr0_r[7:0];
			pcrs_pkg::IDX_P0H_SHD: rd_val = shd_ptr0_r[15:8];
			pcrs_pkg::IDX_P1L_SHD: rd_val = shd_ptr1_r[7:0];
			pcrs_pkg::IDX_P1H_SHD: rd_val = shd_ptr1_r[15:8];
			pcrs_pkg::IDX_STACK_PTR: rd_val = {3'h0, stack_pointer_r};
			pcrs_pkg::IDX_TOS_LOW: rd_val = tos_rdata[7:0];
			pcrs_pkg::IDX_TOS_HIGH: rd_val = {1'b0, tos_rdata[14:8]};
			pcrs_pkg::IDX_PC_LOW: rd_val = pc_r[7:0];
			pcrs_pkg::IDX_PC_LATCH: rd_val = {1'b0, pc_high_latch_r};
			pcrs_pkg::IDX_PWR_CTRL: rd_val = {ovf_r, unf_r, 6'h00};
			pcrs_pkg::IDX_CONFIG: rd_val = {7'h00, fault_en_r};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_r <= 1'b0;
			rresp_r <= pcrs_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= is_mapped(rd_idx) ? pcrs_pkg::RESP_OKAY : pcrs_pkg::RESP_SLVERR;
			rdata_r <= {24'h000000, rd_val};
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	assign pc_out = pc_r;
	assign pc_high_latch_out = pc_high_latch_r;
	assign ctx_restore = restore_r;
	assign shd_status = shd_status_r;
	assign shd_acc = shd_acc_r;
	assign shd_bank = shd_bank_r;
	assign shd_ptr0 = shd_ptr0_r;
	assign shd_ptr1 = shd_ptr1_r;
	assign stack_fault_reset = fault_r;
	assign stack_overflow_flag = ovf_r;
	assign stack_underflow_flag = unf_r;
endmodule // pcrs_core

// ==== dv/pcrs_core_sva.sv ====
/*
 pcrs_core_sva: concurrent checks on the program counter and return stack ports.
 Assumes it is bound into pcrs_core and sees only that module's ports.
*/
module pcrs_core_sva #(
	parameter logic [14:0] VECTOR = pcrs_pkg::INT_VECTOR
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic core_op_valid,
	input wire pcrs_pkg::pcrs_op_t core_op,
	input wire logic [7:0] core_acc,
	input wire logic [10:0] core_operand,
	input wire logic [7:0] core_pcl_data,
	input wire logic [14:0] pc_out,
	input wire logic [6:0] pc_high_latch_out,
	input wire logic ctx_restore,
	input wire logic stack_fault_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [14:0] acc_ext;
	logic [14:0] bra_off;
	assign acc_ext = {7'h00, core_acc};
	assign bra_off = {{6{core_operand[8]}}, core_operand[8:0]};
	sequence op_s(pcrs_pkg::pcrs_op_t o);
		core_op_valid && core_op == o;
	endsequence
	sequence push_pop_s;
		core_op_valid && core_op inside {pcrs_pkg::OP_CALL, pcrs_pkg::OP_CALL_VIA_ACCUMULATOR,
			pcrs_pkg::OP_INT, pcrs_pkg::OP_RETURN, pcrs_pkg::OP_RETURN_WITH_LITERAL};
	endsequence
	sequence pulse_s(logic s);
		s ##1 !s;
	endsequence
	reset_clear_a: assert property ($rose(rstn) |-> pc_out == pcrs_pkg::PC_RST)
		else $error("counter not clear after reset");
	pcl_load_a: assert property (op_s(pcrs_pkg::OP_WR_PCL) |=>
		pc_out == {pc_high_latch_out, $past(core_pcl_data)})
		else $error("low byte write did not load latch bits");
	call_load_a: assert property (op_s(pcrs_pkg::OP_CALL) |=>
		pc_out == {pc_high_latch_out[6:3], $past(core_operand)} || pc_out == pcrs_pkg::PC_RST)
		else $error("call target wrong");
	call_via_accumulator_load_a: assert property (op_s(pcrs_pkg::OP_CALL_VIA_ACCUMULATOR) |=>
		pc_out == {pc_high_latch_out, $past(core_acc)} || pc_out == pcrs_pkg::PC_RST)
		else $error("accumulator call target wrong");
	brw_add_a: assert property (op_s(pcrs_pkg::OP_BRW) |=>
		pc_out == $past(pc_out) + pcrs_pkg::PC_ONE + $past(acc_ext))
		else $error("accumulator branch target wrong");
	bra_add_a: assert property (op_s(pcrs_pkg::OP_BRA) |=>
		pc_out == $past(pc_out) + pcrs_pkg::PC_ONE + $past(bra_off))
		else $error("signed branch target wrong");
	int_vector_a: assert property (op_s(pcrs_pkg::OP_INT) |=>
		pc_out == VECTOR || pc_out == pcrs_pkg::PC_RST)
		else $error("interrupt did not vector");
	latch_hold_a: assert property (push_pop_s |=> $stable(pc_high_latch_out))
		else $error("latch changed by push or pop");
	restore_pulse_a: assert property (op_s(pcrs_pkg::OP_RETURN_FROM_INTERRUPT) |=>
		pulse_s(ctx_restore) or stack_fault_reset)
		else $error("restore pulse missing");
	fault_pulse_a: assert property ($rose(stack_fault_reset) |->
		pc_out == pcrs_pkg::PC_RST ##1 !stack_fault_reset)
		else $error("fault reset pulse wrong");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // pcrs_core_sva

bind pcrs_core pcrs_core_sva #(.VECTOR(VECTOR)) pcrs_core_sva_inst (.clk(clk), .rstn(rstn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .core_op_valid(core_op_valid),
	.core_op(core_op), .core_acc(core_acc), .core_operand(core_operand),
	.core_pcl_data(core_pcl_data), .pc_out(pc_out), .pc_high_latch_out(pc_high_latch_out),
	.ctx_restore(ctx_restore), .stack_fault_reset(stack_fault_reset));

// ==== dv/testbench.sv ====
/*
 testbench: register and core operation sequences for pcrs_core with expected values.
 Assumes the pcrs_core defaults and the checker bound from pcrs_core_sva.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic core_op_valid, ctx_restore, stack_fault_reset, stack_overflow_flag;
	logic stack_underflow_flag;
	pcrs_pkg::pcrs_op_t core_op;
	logic [7:0] core_acc, core_pcl_data, shd_acc;
	logic [10:0] core_operand;
	logic [2:0] ctx_status, shd_status;
	logic [4:0] ctx_bank, shd_bank;
	logic [15:0] ctx_ptr0, ctx_ptr1, shd_ptr0, shd_ptr1;
	logic [14:0] pc_out, exp_pc, pushed;
	logic [6:0] pc_high_latch_out;
	int num_errors, checks_done, fault_pulses, restore_pulses, i;
	pcrs_core pcrs_core_inst (.*);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		if (stack_fault_reset === 1'b1) fault_pulses++;
		if (ctx_restore === 1'b1) restore_pulses++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic aw_hs, w_hs, b_hs;
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid && s_axi_bready;
			resp = s_axi_bresp;
			@(posedge clk);
			if (aw_hs) s_axi_awvalid <= 1'b0;
			if (w_hs) s_axi_wvalid <= 1'b0;
			if (b_hs) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) num_errors++;
		chk(32'(resp), 32'(er));
	endtask
	task automatic axi_rd(input logic [11:0] idx, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic ar_hs, r_hs;
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ar_hs) s_axi_arvalid <= 1'b0;
			if (r_hs) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) num_errors++;
		chk(rd, ed);
		chk(32'(resp), 32'(er));
	endtask
	task automatic core(input pcrs_pkg::pcrs_op_t o, input logic [10:0] opd, input logic [7:0] a);
		@(posedge clk);
		core_op_valid <= 1'b1;
		core_op <= o;
		core_operand <= opd;
		core_acc <= a;
		core_pcl_data <= a;
		@(posedge clk);
		core_op_valid <= 1'b0;
		@(negedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{core_op_valid, core_acc, core_operand, core_pcl_data} = '0;
		core_op = pcrs_pkg::OP_HOLD;
		{ctx_status, ctx_bank, ctx_ptr0, ctx_ptr1} = '0;
		rstn = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(32'(pc_out), 32'h0);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h1f, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_PC_LATCH, 32'h0, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_PC_LATCH, 8'h55, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_WR_PCL, 11'h000, 8'h3c);
		chk(32'(pc_out), 32'h553c);
		$display("test reset_and_low_byte ends");
		core(pcrs_pkg::OP_CALL, 11'h123, 8'h00);
		chk(32'(pc_out), 32'h5123);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h00, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_TOS_LOW, 32'h3d, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_TOS_HIGH, 32'h55, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_CALL_VIA_ACCUMULATOR, 11'h000, 8'h80);
		chk(32'(pc_out), 32'h5580);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h01, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_RETURN_WITH_LITERAL, 11'h000, 8'h00);
		chk(32'(pc_out), 32'h5124);
		core(pcrs_pkg::OP_RETURN, 11'h000, 8'h00);
		chk(32'(pc_out), 32'h553d);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h1f, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_PC_LATCH, 32'h55, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_BRW, 11'h000, 8'hff);
		chk(32'(pc_out), 32'h563d);
		core(pcrs_pkg::OP_BRA, 11'h100, 8'h00);
		chk(32'(pc_out), 32'h553e);
		core(pcrs_pkg::OP_BRA, 11'h0ff, 8'h00);
		chk(32'(pc_out), 32'h563e);
		$display("test calls_and_branches ends");
		axi_wr(pcrs_pkg::IDX_STACK_PTR, 8'h00, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_TOS_LOW, 8'h11, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_TOS_HIGH, 8'hff, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_TOS_HIGH, 32'h7f, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_RETURN, 11'h000, 8'h00);
		chk(32'(pc_out), 32'h7f11);
		core(pcrs_pkg::OP_RETURN, 11'h000, 8'h00);
		axi_rd(pcrs_pkg::IDX_PWR_CTRL, 32'h40, pcrs_pkg::RESP_OKAY);
		chk(32'({stack_overflow_flag, stack_underflow_flag}), 32'h1);
		axi_wr(pcrs_pkg::IDX_PWR_CTRL, 8'h00, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_STACK_PTR, 8'h1f, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_WR_PCL, 11'h000, 8'h00);
		exp_pc = 15'h5500;
		for (i = 0; i < 17; i++) begin
			core(pcrs_pkg::OP_CALL, 11'(i), 8'h00);
			pushed = exp_pc + 15'h0001;
			exp_pc = {4'ha, 11'(i)};
		end
		chk(32'(pc_out), 32'(exp_pc));
		axi_rd(pcrs_pkg::IDX_PWR_CTRL, 32'h80, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h10, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_STACK_PTR, 8'h00, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_TOS_LOW, 32'(pushed[7:0]), pcrs_pkg::RESP_OKAY);
		$display("test stack_access_and_wrap ends");
		axi_wr(pcrs_pkg::IDX_PWR_CTRL, 8'h00, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_CONFIG, 8'h01, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_STACK_PTR, 8'h0f, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_CALL, 11'h7ff, 8'h00);
		repeat (2) @(negedge clk);
		chk(32'(pc_out), 32'h0);
		chk(32'(fault_pulses), 32'h1);
		axi_rd(pcrs_pkg::IDX_STACK_PTR, 32'h1f, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_RETURN, 11'h000, 8'h00);
		repeat (2) @(negedge clk);
		chk(32'(fault_pulses), 32'h2);
		axi_rd(pcrs_pkg::IDX_PWR_CTRL, 32'hc0, pcrs_pkg::RESP_OKAY);
		chk(32'({stack_overflow_flag, stack_underflow_flag}), 32'h3);
		axi_wr(pcrs_pkg::IDX_CONFIG, 8'h00, pcrs_pkg::RESP_OKAY);
		$display("test fault_reset ends");
		axi_wr(pcrs_pkg::IDX_PC_LATCH, 8'h2a, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_WR_PCL, 11'h000, 8'h77);
		@(posedge clk);
		ctx_status <= 3'h5;
		ctx_bank <= 5'h13;
		ctx_ptr0 <= 16'h1234;
		ctx_ptr1 <= 16'h5678;
		core(pcrs_pkg::OP_INT, 11'h000, 8'h9c);
		chk(32'(pc_out), 32'(pcrs_pkg::INT_VECTOR));
		chk({16'h0, shd_acc, shd_status, shd_bank}, 32'h9cb3);
		chk({shd_ptr1, shd_ptr0}, 32'h56781234);
		axi_rd(pcrs_pkg::IDX_WORK_SHD, 32'h9c, pcrs_pkg::RESP_OKAY);
		axi_rd(pcrs_pkg::IDX_PCH_SHD, 32'h2a, pcrs_pkg::RESP_OKAY);
		axi_wr(pcrs_pkg::IDX_PC_LATCH, 8'h11, pcrs_pkg::RESP_OKAY);
		core(pcrs_pkg::OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00);
		@(negedge clk);
		chk(32'(pc_out), 32'h2a77);
		chk(32'(pc_high_latch_out), 32'h2a);
		chk(32'(restore_pulses), 32'h1);
		axi_rd(12'h000, 32'h0, pcrs_pkg::RESP_SLVERR);
		axi_wr(12'h000, 8'hff, pcrs_pkg::RESP_SLVERR);
		$display("test interrupt_context ends");
		close_out();
	end
endmodule // testbench
